//--- rtl/sss_top.sv
// Purpose: Wake qualification, rail sequencing and supervision outputs
// Assumes: Sense levels are asynchronous comparator outputs
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.svh"

module sss_top #(
	parameter int WPL_CYC         = `SSS_WPL_CYC,
	parameter int RST_ACT_CYC     = `SSS_RST_ACT_CYC,
	parameter int WDG_TIMEOUT_CYC = `SSS_WDG_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	// Analog comparators and straps
	input  wire sss_pkg::sss_sense_t sense,
	// Pin and regulator drive
	output var  sss_pkg::sss_drive_t drive,
	output var  sss_pkg::sss_mode_t  mode
);
	import sss_pkg::*;

	localparam logic [`SSS_HOLD_W-1:0] HOLD_LOAD =
		`SSS_HOLD_W'(RST_ACT_CYC - 1);
	localparam logic [`SSS_WDG_W-1:0] WDG_LIM =
		`SSS_WDG_W'(WDG_TIMEOUT_CYC - 1);

	sss_state_t st_ff;
	sss_state_t nxt_st;
	sss_sense_t s;
	logic       wake_q;
	logic [2:0] rail_fault;
	logic       bat_ov_f;
	logic       bat_uv_f;
	logic       cp_uv_f;
	logic       warn_f;
	logic       safe_req;
	logic       evt;
	logic       wdg_edge;
	logic [2:0] rail_en;
	logic [2:0] rail_low;

	// Second sync stage only; the first is read only to feed the second
	assign s = st_ff.sync2;

	// ------------------------------------------------------------
	// Condition filters
	// ------------------------------------------------------------
	sss_filter #(.SET_CYC(`SSS_WPH_CYC), .CLR_CYC(WPL_CYC)) u_wake (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.set_cond (s.wake),     // [RL2]
		.clr_cond (!s.wake),    // [RL6]
		.level    (wake_q)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_rail
			sss_filter #(
				.SET_CYC(`SSS_RAIL_FILT_CYC),
				.CLR_CYC(`SSS_RAIL_FILT_CYC)
			) u_rail (
				.ref_clk  (ref_clk),
				.arst_n   (arst_n),
				.set_cond (s.rail_uv[gi] | s.rail_ov[gi]),   // [RL21]
				.clr_cond (!(s.rail_uv[gi] | s.rail_ov[gi])),
				.level    (rail_fault[gi])
			);
		end
	endgenerate

	// Battery windows exit on the opposite hysteresis comparator
	sss_filter #(.SET_CYC(`SSS_SUP_FILT_CYC), .CLR_CYC(`SSS_SUP_FILT_CYC))
	u_bat_ov (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.set_cond (s.bat_ov_high),  // [RL16] [RL22]
		.clr_cond (s.bat_ov_low),
		.level    (bat_ov_f)
	);

	sss_filter #(.SET_CYC(`SSS_SUP_FILT_CYC), .CLR_CYC(`SSS_SUP_FILT_CYC))
	u_bat_uv (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.set_cond (s.bat_uv_low),   // [RL16] [RL22]
		.clr_cond (s.bat_uv_high),
		.level    (bat_uv_f)
	);

	sss_filter #(.SET_CYC(`SSS_SUP_FILT_CYC), .CLR_CYC(`SSS_SUP_FILT_CYC))
	u_cp (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.set_cond (s.cp_uv),        // [RL17] [RL22]
		.clr_cond (!s.cp_uv),
		.level    (cp_uv_f)
	);

	sss_filter #(.SET_CYC(`SSS_TWN_DEGL_CYC), .CLR_CYC(`SSS_TWN_DEGL_CYC))
	u_warn (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.set_cond (s.temp_warn_high),  // [RL13] [RL24]
		.clr_cond (s.temp_below_low),
		.level    (warn_f)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.sync1 = sense;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.wdg_prev = s.watchdog_toggle_in;
		wdg_edge = s.watchdog_toggle_in ^ st_ff.wdg_prev;

		// Shutdown holds until the die cools below the low limit
		if (s.temp_shutdown) begin
			nxt_st.tsd_hold = 1'b1; // [RL14]
		end else if (s.temp_below_low) begin
			nxt_st.tsd_hold = 1'b0; // [RL14]
		end

		safe_req = bat_ov_f | bat_uv_f | cp_uv_f | st_ff.tsd_hold; // [RL16] [RL17]

		// Count each new protective event; stop at the latch limit
		evt = cp_uv_f | st_ff.wdg_fault | s.temp_shutdown;
		nxt_st.evt_prev = evt;
		if (evt && !st_ff.evt_prev && st_ff.latch_cnt != `SSS_LATCH_LIMIT) begin
			nxt_st.latch_cnt = st_ff.latch_cnt + 3'h1; // [RL18]
		end

		unique case (st_ff.mode)
			SSS_OFF: begin
				nxt_st.latch_cnt = '0;
				if (wake_q && s.bat_start_ok) begin
					nxt_st.mode = SSS_INT_UP; // [RL1]
				end
			end
			SSS_INT_UP: begin
				if (safe_req) begin
					nxt_st.mode = SSS_SAFE;
				end else if (s.internal_ready) begin
					nxt_st.mode = s.primary_used ? SSS_PRI_UP   // [RL3]
						: SSS_ACTIVE;                            // [RL5]
				end
			end
			SSS_PRI_UP: begin
				if (safe_req) begin
					nxt_st.mode = SSS_SAFE;
				end else if (!s.rail_uv[0]) begin
					nxt_st.mode = SSS_ACTIVE; // [RL4]
				end
			end
			SSS_ACTIVE: begin
				if (safe_req) begin
					nxt_st.mode = SSS_SAFE; // [RL14] [RL16] [RL17]
				end
			end
			SSS_SAFE: begin
				if (!safe_req) begin
					nxt_st.mode = SSS_INT_UP;
				end
			end
			SSS_LATCH: begin
			end
			default: begin
				nxt_st.mode = SSS_OFF;
			end
		endcase

		if (nxt_st.latch_cnt == `SSS_LATCH_LIMIT) begin
			nxt_st.mode = SSS_LATCH; // [RL18]
		end
		if (!wake_q) begin
			nxt_st.mode = SSS_OFF; // [RL6]
		end

		// Watchdog runs only while the rails are up; a toggle wins
		if (nxt_st.mode != SSS_ACTIVE) begin
			nxt_st.wdg_cnt   = '0;
			nxt_st.wdg_fault = 1'b0;
		end else if (wdg_edge) begin
			nxt_st.wdg_cnt   = '0;
			nxt_st.wdg_fault = 1'b0; // [RL12]
		end else if (st_ff.wdg_cnt == WDG_LIM) begin
			nxt_st.wdg_fault = 1'b1; // [RL12]
		end else begin
			nxt_st.wdg_cnt = st_ff.wdg_cnt + 1'b1;
		end

		rail_en[0] = s.primary_used &&
			(nxt_st.mode == SSS_PRI_UP || nxt_st.mode == SSS_ACTIVE); // [RL3]
		rail_en[1] = nxt_st.mode == SSS_ACTIVE; // [RL4] [RL5]
		rail_en[2] = nxt_st.mode == SSS_ACTIVE;

		// Per rail: low until first good, then hold after each fault
		for (int i = 0; i < 3; i++) begin
			if (!rail_en[i]) begin
				nxt_st.rail_up[i]  = 1'b0;
				nxt_st.hold_cnt[i] = '0;
				rail_low[i]        = 1'b1;
			end else if (!st_ff.rail_up[i]) begin
				nxt_st.rail_up[i] = !s.rail_uv[i]; // [RL15]
				rail_low[i]       = 1'b1;
			end else if (rail_fault[i]) begin
				nxt_st.hold_cnt[i] = HOLD_LOAD; // [RL7] [RL9] [RL11]
				rail_low[i]        = 1'b1;
			end else if (st_ff.hold_cnt[i] != '0) begin
				nxt_st.hold_cnt[i] = st_ff.hold_cnt[i] - 1'b1; // [RL8] [RL10] [RL23]
				rail_low[i]        = 1'b1;
			end else begin
				rail_low[i] = 1'b0;
			end
		end

		nxt_st.drv.internal_regulator_en =
			nxt_st.mode inside {SSS_INT_UP, SSS_PRI_UP, SSS_ACTIVE, SSS_SAFE};
		nxt_st.drv.primary_regulator_en    = rail_en[0];
		nxt_st.drv.secondary_regulator_en  = rail_en[1];
		nxt_st.drv.adc_linear_regulator_en = rail_en[2];
		nxt_st.drv.adc_target_5v = s.adc_voltage_select; // [RL20]
		// Reset style pins idle high; all low while off, except primary reset when primary_used is low
		nxt_st.drv.primary_rail_reset_n   = !rail_low[0] || !s.primary_used;
		nxt_st.drv.secondary_rail_reset_n = !rail_low[1]; // [RL19]
		nxt_st.drv.adc_rail_good_n        = !rail_low[2];
		// Open drain pins: only ever pull low or release
		nxt_st.drv.thermal_warn_n_o    = 1'b0; // [RL19]
		nxt_st.drv.thermal_warn_n_oe   = warn_f && nxt_st.mode != SSS_OFF;
		nxt_st.drv.watchdog_fault_n_o  = 1'b0;
		nxt_st.drv.watchdog_fault_n_oe = nxt_st.wdg_fault;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff      <= '0;
			st_ff.mode <= SSS_OFF;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign drive = st_ff.drv;
	assign mode  = st_ff.mode;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence seq_pri_settled;
		st_ff.mode == SSS_PRI_UP && !safe_req && wake_q && !s.rail_uv[0]
			&& st_ff.latch_cnt != `SSS_LATCH_LIMIT;
	endsequence

	sequence seq_direct_start;
		st_ff.mode == SSS_INT_UP && !safe_req && wake_q && s.internal_ready
			&& !s.primary_used && st_ff.latch_cnt != `SSS_LATCH_LIMIT;
	endsequence

	AST_EN_NEEDS_WAKE: assert property ( // [RL1]
		$rose(drive.internal_regulator_en) && $past(mode) == SSS_OFF
			|-> $past(wake_q) && $past(s.bat_start_ok))
		else $error("regulators enabled without wake and battery");
	AST_PRI_FIRST: assert property ( // [RL3]
		$rose(drive.secondary_regulator_en) && s.primary_used
			|-> $past(drive.primary_regulator_en))
		else $error("secondary started before primary");
	AST_SEC_AFTER_PRI: assert property ( // [RL4]
		seq_pri_settled |=> drive.secondary_regulator_en
			&& drive.adc_linear_regulator_en)
		else $error("secondary and ADC not started after primary good");
	AST_NO_PRI: assert property ( // [RL5]
		seq_direct_start |=> mode == SSS_ACTIVE
			&& !drive.primary_regulator_en && drive.adc_linear_regulator_en)
		else $error("direct start without primary failed");
	AST_WAKE_LOW_OFF: assert property ( // [RL6]
		!wake_q |=> mode == SSS_OFF && !drive.internal_regulator_en
			&& !drive.secondary_regulator_en && !drive.thermal_warn_n_oe)
		else $error("outputs not deactivated after wake low");
	AST_RST_HOLD: assert property ( // [RL8]
		$fell(rail_fault[0]) && mode == SSS_ACTIVE && wake_q && !safe_req
			&& s.primary_used |=> !drive.primary_rail_reset_n [*8])
		else $error("primary reset released too early");
	AST_TSD_SAFE: assert property ( // [RL14]
		mode == SSS_ACTIVE && st_ff.tsd_hold && wake_q
			|=> mode inside {SSS_SAFE, SSS_LATCH})
		else $error("shutdown temperature did not enter safe");
	AST_WARN_OUT: assert property ( // [RL13]
		warn_f && mode != SSS_OFF && wake_q ##1 mode != SSS_OFF
			|-> drive.thermal_warn_n_oe && !drive.thermal_warn_n_o)
		else $error("thermal warning not driven low");
	AST_WDG_FAULT: assert property ( // [RL12]
		st_ff.wdg_cnt == WDG_LIM && !wdg_edge && nxt_st.mode == SSS_ACTIVE
			|=> drive.watchdog_fault_n_oe)
		else $error("watchdog timeout not flagged");
	AST_LATCH: assert property ( // [RL18]
		st_ff.latch_cnt == `SSS_LATCH_LIMIT && wake_q |=> mode == SSS_LATCH
			&& !drive.internal_regulator_en)
		else $error("repeated faults did not latch");

endmodule

`default_nettype wire

//--- rtl/sss_regs.svh
// Purpose: Timing counts and limits of the supply sequencer supervisor
// Assumes: 20 MHz reference clock
// Notes:   Counts derive from printed times; long ones feed top parameters
//
// Functional notes
// RL1: Enable internal regulators only with battery above 5.5 V and wake qualified.
// RL2: Accept rising wake only after it persists for 150 us.
// RL3: With internal regulators ready, start primary regulator first with soft start.
// RL4: Primary rail above under-voltage enables secondary and ADC regulators.
// RL5: Without primary regulator, start secondary and ADC right after internal ready.
// RL6: Wake low for 1 ms disables internal regulators and all outputs.
// RL7: Persisting primary under/over-voltage drives primary reset low.
// RL8: Primary reset stays low the active duration after its fault clears.
// RL9: Persisting secondary under/over-voltage drives secondary reset low.
// RL10: Secondary reset stays low the active duration after its fault clears.
// RL11: Persisting ADC rail fault drives ADC monitor low, released after hold time.
// RL12: Supervise watchdog toggles; drive watchdog fault low on a fault.
// RL13: Thermal warning low above high limit, released below low limit.
// RL14: Above shutdown limit go safe; return to active below low limit.
// RL15: At power-up hold resets and ADC monitor low until rails pass under-voltage.
// RL16: Battery over/under-voltage beyond filter time enters safe; hysteresis exit.
// RL17: Charge-pump under-voltage beyond filter time enters safe; same time to exit.
// RL18: Repeated charge-pump, watchdog or thermal faults enter latched disable.
// RL19: Warning and watchdog outputs pull low or float; resets idle high.
// RL20: ADC select low picks 3.3 V target, high picks 5.0 V and thresholds.
// RL21: Rail fault filter time is 200 us.
// RL22: Battery and charge-pump fault filter time is 64 us.
// RL23: Reset and ADC monitor hold time after fault is 15 ms.
// RL24: Thermal warning deglitch time is 10 us.
// RL25: Filter timers restart from zero when their condition drops out.
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH

`define SSS_CLK_MHZ         20
`define SSS_BAT_START_MV    5500
`define SSS_ADC_LOW_MV      3300
`define SSS_ADC_HIGH_MV     5000

`define SSS_WPH_US          150
`define SSS_WPH_CYC         (`SSS_WPH_US * `SSS_CLK_MHZ)
`define SSS_WPL_MS          1
`define SSS_WPL_CYC         (`SSS_WPL_MS * 1000 * `SSS_CLK_MHZ)
`define SSS_RAIL_FILT_US    200
`define SSS_RAIL_FILT_CYC   (`SSS_RAIL_FILT_US * `SSS_CLK_MHZ)
`define SSS_SUP_FILT_US     64
`define SSS_SUP_FILT_CYC    (`SSS_SUP_FILT_US * `SSS_CLK_MHZ)
`define SSS_RST_ACT_MS      15
`define SSS_RST_ACT_CYC     (`SSS_RST_ACT_MS * 1000 * `SSS_CLK_MHZ)
`define SSS_TWN_DEGL_US     10
`define SSS_TWN_DEGL_CYC    (`SSS_TWN_DEGL_US * `SSS_CLK_MHZ)
`define SSS_WDG_TIMEOUT_US  10000
`define SSS_WDG_TIMEOUT_CYC (`SSS_WDG_TIMEOUT_US * `SSS_CLK_MHZ)

`define SSS_FILT_W          16
`define SSS_HOLD_W          19
`define SSS_WDG_W           18
`define SSS_LATCH_LIMIT     3'h4

`endif

//--- rtl/sss_pkg.sv
// Purpose: Types of the supply sequencer supervisor
// Assumes: Rail index 0 primary, 1 secondary, 2 ADC
// Notes:   Sense bits are raw comparator levels from the analog side
`include "sss_regs.svh"

package sss_pkg;

	typedef struct packed {
		logic       wake;
		logic       bat_start_ok;
		logic       bat_ov_high;
		logic       bat_ov_low;
		logic       bat_uv_low;
		logic       bat_uv_high;
		logic       cp_uv;
		logic [2:0] rail_uv;
		logic [2:0] rail_ov;
		logic       temp_warn_high;
		logic       temp_below_low;
		logic       temp_shutdown;
		logic       internal_ready;
		logic       primary_used;
		logic       watchdog_toggle_in;
		logic       adc_voltage_select;
	} sss_sense_t;

	typedef enum logic [5:0] {
		SSS_OFF    = 6'b00_0001,
		SSS_INT_UP = 6'b00_0010,
		SSS_PRI_UP = 6'b00_0100,
		SSS_ACTIVE = 6'b00_1000,
		SSS_SAFE   = 6'b01_0000,
		SSS_LATCH  = 6'b10_0000
	} sss_mode_t;

	typedef struct packed {
		logic internal_regulator_en;
		logic primary_regulator_en;
		logic secondary_regulator_en;
		logic adc_linear_regulator_en;
		logic adc_target_5v;
		logic primary_rail_reset_n;
		logic secondary_rail_reset_n;
		logic adc_rail_good_n;
		logic thermal_warn_n_o;
		logic thermal_warn_n_oe;
		logic watchdog_fault_n_o;
		logic watchdog_fault_n_oe;
	} sss_drive_t;

	typedef struct packed {
		logic [`SSS_FILT_W-1:0] cnt;
		logic                   out;
	} sss_filt_st_t;

	typedef struct packed {
		sss_sense_t                   sync1;
		sss_sense_t                   sync2;
		logic                         wdg_prev;
		sss_mode_t                    mode;
		logic [2:0]                   rail_up;
		logic [2:0][`SSS_HOLD_W-1:0]  hold_cnt;
		logic                         tsd_hold;
		logic [`SSS_WDG_W-1:0]        wdg_cnt;
		logic                         wdg_fault;
		logic [2:0]                   latch_cnt;
		logic                         evt_prev;
		sss_drive_t                   drv;
	} sss_state_t;

endpackage

//--- rtl/sss_filter.sv
// Purpose: Persistence filter with separate set and clear times
// Assumes: Conditions are synchronous to ref_clk
// Notes:   Output flips only after its condition holds for the full time
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.svh"

module sss_filter #(
	parameter int SET_CYC = 16,
	parameter int CLR_CYC = 16
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// Conditions
	input  wire logic set_cond,
	input  wire logic clr_cond,
	// Qualified level
	output var  logic level
);
	import sss_pkg::*;

	localparam logic [`SSS_FILT_W-1:0] SET_LIM = `SSS_FILT_W'(SET_CYC - 1);
	localparam logic [`SSS_FILT_W-1:0] CLR_LIM = `SSS_FILT_W'(CLR_CYC - 1);

	sss_filt_st_t st_ff;
	sss_filt_st_t nxt_st;
	logic         cond;
	logic [`SSS_FILT_W-1:0] lim;

	always_comb begin
		nxt_st = st_ff;
		cond   = st_ff.out ? clr_cond : set_cond;
		lim    = st_ff.out ? CLR_LIM : SET_LIM;
		if (!cond) begin
			nxt_st.cnt = '0; // [RL25]
		end else if (st_ff.cnt == lim) begin
			nxt_st.out = ~st_ff.out;
			nxt_st.cnt = '0;
		end else begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.out;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	AST_FILT_FIRE: assert property ( // [RL2]
		!st_ff.out && set_cond && st_ff.cnt == SET_LIM |=> st_ff.out)
		else $error("filter did not fire at set time");
	AST_FILT_RESTART: assert property ( // [RL25]
		!st_ff.out && !set_cond |=> st_ff.cnt == '0 && !st_ff.out)
		else $error("filter did not restart on dropout");

endmodule

`default_nettype wire

//--- verif/sss_host_model.sv
// Purpose: Host controller that services the watchdog toggle
// Assumes: Toggle is launched on the falling ref_clk edge
// Notes:   Bench can stop it to starve the watchdog on purpose
`timescale 1ns/1ps
`default_nettype none

module sss_host_model (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Bench control
	input  wire logic       enable,
	input  wire logic [7:0] half_period,
	// Watchdog toggle pin
	output var  logic       toggle
);
	int cnt;

	// ------------------------------------------------
	// Toggle generator
	// ------------------------------------------------
	// Falling edge launch keeps toggles clear of the sampling edge
	always @(negedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			toggle <= 1'b0;
		end else if (enable && cnt >= int'(half_period)) begin
			cnt <= 0;
			toggle <= ~toggle;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

//--- verif/sss_top_tb_top.sv
// Purpose: Self-checking bench of the supply sequencer supervisor
// Assumes: Short wake-low, hold and timeout parameters, other filter counts fixed
// Notes:   Windows allow a few cycles of sync and register latency
`timescale 1ns/1ps
`default_nettype none

module sss_top_tb_top;
	import sss_pkg::*;

	localparam int wake_low_qualify_time = 40;
	localparam int rst_act = 50;
	localparam int wdg_to = 100;
	localparam int b_pri = 10;
	localparam int b_adc = 8;
	localparam int b_5v = 7;
	localparam int b_rst1 = 6;
	localparam int b_good = 4;
	localparam int b_two = 3;
	localparam int b_twe = 2;
	localparam int b_wdo = 1;
	localparam int b_wde = 0;
	localparam int m_off = 12;
	localparam int m_int = 13;
	localparam int m_pri = 14;
	localparam int m_act = 15;
	localparam int m_safe = 16;
	localparam int m_latch = 17;

	logic        ref_clk;
	logic        arst_n;
	sss_sense_t  sns;
	sss_sense_t  dut_sense;
	sss_drive_t  drive;
	sss_mode_t   mode;
	logic [17:0] obs;
	logic        host_en;
	logic [7:0]  host_half;
	logic        host_tgl;
	logic [31:0] rnd;
	int          err_count;
	int          tests_run;
	int          r;
	int          f;
	int          k;

	assign obs = {mode, drive};

	always_comb begin
		dut_sense = sns;
		dut_sense.watchdog_toggle_in = host_tgl;
	end

	sss_top #(
		.WPL_CYC        (wake_low_qualify_time),
		.RST_ACT_CYC    (rst_act),
		.WDG_TIMEOUT_CYC(wdg_to)
	) u_dut (
		.ref_clk(ref_clk),
		.arst_n (arst_n),
		.sense  (dut_sense),
		.drive  (drive),
		.mode   (mode)
	);

	sss_host_model u_host (
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.enable     (host_en),
		.half_period(host_half),
		.toggle     (host_tgl)
	);

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic next_rnd(input int lo, input int span, output int v);
		rnd = xs(rnd);
		v = lo + int'(rnd % 32'(span));
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Early change is as wrong as a late one
	task automatic wait_sig(input int b, input logic v, input int lo,
		input int hi);
		int n;
		n = 0;
		while (obs[b] !== v) begin
			if (n == hi) begin
				check(obs[b], v);
				finish_test();
			end
			@(negedge ref_clk);
			n++;
		end
		check(n >= lo, 1'b1);
	endtask

	task automatic hold_sig(input int b, input logic v, input int n);
		logic ok;
		ok = 1'b1;
		repeat (n) begin
			@(negedge ref_clk);
			ok = ok & (obs[b] === v);
		end
		check(ok, 1'b1);
	endtask

	task automatic rail_fault(input int i, input int kind, input logic v);
		if (kind[0]) begin
			sns.rail_ov[i] = v;
		end else begin
			sns.rail_uv[i] = v;
		end
	endtask

	task automatic safe_set(input int i, input logic enter, input logic ok);
		case (i)
			0: begin
				sns.bat_ov_high = enter;
				sns.bat_ov_low = ok;
			end
			1: begin
				sns.bat_uv_low = enter;
				sns.bat_uv_high = ok;
			end
			default: sns.cp_uv = enter;
		endcase
	endtask

	// ------------------------------------------------
	// Clock and sequence
	// ------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial begin
		rnd = 32'h1eb3_f8f9;
		err_count = 0;
		tests_run = 0;
		arst_n = 1'b0;
		// Host samples on the falling edge too; update after it
		host_en <= 1'b0;
		host_half <= 8'h0a;
		sns = '0;
		sns.bat_ov_low = 1'b1;
		sns.bat_uv_high = 1'b1;
		sns.temp_below_low = 1'b1;
		sns.primary_used = 1'b1;
		cyc(16);
		arst_n = 1'b1;
		check(obs, {SSS_OFF, 12'h000});
		sns.wake = 1'b1;
		hold_sig(m_off, 1'b1, 3100);
		check(obs[11], 1'b0);
		sns.wake = 1'b0;
		cyc(60);
		sns.bat_start_ok = 1'b1;
		next_rnd(500, 2400, r);
		sns.wake = 1'b1;
		cyc(r);
		sns.wake = 1'b0;
		cyc(4);
		sns.wake = 1'b1;
		sns.rail_uv = 3'h7;
		wait_sig(m_int, 1'b1, 2990, 3020);
		check(obs[b_rst1:b_good], 3'h0);
		sns.internal_ready = 1'b1;
		wait_sig(m_pri, 1'b1, 0, 10);
		check(obs[b_pri:b_adc], 3'h4);
		sns.rail_uv[0] = 1'b0;
		wait_sig(m_act, 1'b1, 0, 10);
		check(obs[b_pri:b_adc], 3'h7);
		// Reset release trails the rail-up mark by one edge
		cyc(1);
		check(obs[b_rst1:b_good], 3'h4);
		sns.rail_uv = 3'h0;
		next_rnd(2, 38, r);
		host_half <= r[7:0];
		host_en <= 1'b1;
		wait_sig(b_good, 1'b1, 0, 10);
		check(obs[b_rst1:b_good], 3'h7);
		for (k = 0; k < 4; k++) begin
			next_rnd(0, 2, r);
			sns.adc_voltage_select = r[0];
			cyc(4);
			check(obs[b_5v], r[0]);
		end
		// Rail faults with a dropout first: the filter must restart
		for (k = 0; k < 3; k++) begin
			next_rnd(0, 2, f);
			next_rnd(1000, 2900, r);
			rail_fault(k, f, 1'b1);
			cyc(r);
			rail_fault(k, f, 1'b0);
			cyc(3);
			rail_fault(k, f, 1'b1);
			wait_sig(b_rst1 - k, 1'b0, 3990, 4020);
			rail_fault(k, f, 1'b0);
			wait_sig(b_rst1 - k, 1'b1, 4045, 4070);
		end
		hold_sig(b_wde, 1'b0, 3 * wdg_to);
		host_en <= 1'b0;
		wait_sig(b_wde, 1'b1, wdg_to - 45, wdg_to + 20);
		check(obs[b_wdo], 1'b0);
		host_en <= 1'b1;
		wait_sig(b_wde, 1'b0, 0, 60);
		sns.temp_below_low = 1'b0;
		sns.temp_warn_high = 1'b1;
		cyc(150);
		sns.temp_warn_high = 1'b0;
		cyc(3);
		sns.temp_warn_high = 1'b1;
		wait_sig(b_twe, 1'b1, 190, 215);
		check(obs[b_two], 1'b0);
		sns.temp_warn_high = 1'b0;
		hold_sig(b_twe, 1'b1, 400);
		sns.temp_below_low = 1'b1;
		wait_sig(b_twe, 1'b0, 0, 215);
		for (k = 0; k < 3; k++) begin
			safe_set(k, 1'b1, 1'b0);
			wait_sig(m_safe, 1'b1, 1270, 1300);
			check(obs[b_pri:b_adc], 3'h0);
			safe_set(k, 1'b0, 1'b0);
			if (k < 2) begin
				hold_sig(m_safe, 1'b1, 1500);
			end
			safe_set(k, 1'b0, 1'b1);
			wait_sig(m_act, 1'b1, 1270, 1400);
		end
		sns.temp_below_low = 1'b0;
		sns.temp_shutdown = 1'b1;
		wait_sig(m_safe, 1'b1, 0, 10);
		check(obs[b_pri:b_adc], 3'h0);
		sns.temp_shutdown = 1'b0;
		hold_sig(m_safe, 1'b1, 300);
		sns.temp_below_low = 1'b1;
		wait_sig(m_act, 1'b1, 0, 20);
		sns.cp_uv = 1'b1;
		wait_sig(m_latch, 1'b1, 1270, 1310);
		sns.cp_uv = 1'b0;
		hold_sig(m_latch, 1'b1, 1500);
		sns.wake = 1'b0;
		wait_sig(m_off, 1'b1, wake_low_qualify_time - 2, wake_low_qualify_time + 20);
		// Target select is a live strap copy, not a pin drive
		check(drive, {4'h0, sns.adc_voltage_select, 7'h00});
		sns.primary_used = 1'b0;
		sns.wake = 1'b1;
		wait_sig(m_act, 1'b1, 2990, 3040);
		check(obs[b_pri:b_adc], 3'h3);
		finish_test();
	end
endmodule
`default_nettype wire
